// ### core/sptap_core.sv
/*
 * serial program tap: test-port controller, instruction and data registers, and the
 * hand-off of committed configuration words to the system clock domain.
 * assumes tck comes from the external master; tms and tdi change on falling tck.
 */
// Functional notes
// - there is no boundary-scan register; the port only programs and reads back.
// - the port behaves as a compliant member of a serial chain.
// - a one-bit bypass stage links tdi to tdo when nothing else is selected.
// - every boundary-scan instruction selects the bypass stage.
// - a fixed identification word can be read through the port.
// - six further data registers are selectable beyond bypass and identification.
// - most of those registers load and read back configuration and logic-array bits.
// - a status register reports the twelve comparator outputs.
// - the held instruction decides the connected data register and later action.
// - selected registers shift out their contents so the master can verify them.
// - the instruction register is six bits and codes shift as six-bit words.
// - the all-ones code selects bypass and leaves normal operation alone.
// - capture of the instruction register loads the identification instruction.
// - tdi and tms are sampled on rising tck and tdo changes on falling tck.
`timescale 1ns/10ps
`include "sptap_cfg.svh"
module sptap_core (
	// system clock domain
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic ce,
	// test port
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	output logic tdo,
	output logic tdo_oe,
	// comparator levels
	input wire logic [`SPTAP_L_STAT-1:0] cmp_in,
	// committed configuration
	output sptap_pkg::sptap_nv_t nv_out,
	output logic nv_strobe
);
	// ************
	// functions
	// ************
	function automatic sptap_pkg::sptap_state_t tap_next(sptap_pkg::sptap_state_t s, logic m);
		case (s)
			sptap_pkg::ST_RESET: tap_next = m ? sptap_pkg::ST_RESET : sptap_pkg::ST_IDLE;
			sptap_pkg::ST_IDLE: tap_next = m ? sptap_pkg::ST_SEL_DR : sptap_pkg::ST_IDLE;
			sptap_pkg::ST_SEL_DR: tap_next = m ? sptap_pkg::ST_SEL_IR : sptap_pkg::ST_CAP_DR;
			sptap_pkg::ST_CAP_DR: tap_next = m ? sptap_pkg::ST_EX1_DR : sptap_pkg::ST_SH_DR;
			sptap_pkg::ST_SH_DR: tap_next = m ? sptap_pkg::ST_EX1_DR : sptap_pkg::ST_SH_DR;
			sptap_pkg::ST_EX1_DR: tap_next = m ? sptap_pkg::ST_UP_DR : sptap_pkg::ST_PA_DR;
			sptap_pkg::ST_PA_DR: tap_next = m ? sptap_pkg::ST_EX2_DR : sptap_pkg::ST_PA_DR;
			sptap_pkg::ST_EX2_DR: tap_next = m ? sptap_pkg::ST_UP_DR : sptap_pkg::ST_SH_DR;
			sptap_pkg::ST_UP_DR: tap_next = m ? sptap_pkg::ST_SEL_DR : sptap_pkg::ST_IDLE;
			sptap_pkg::ST_SEL_IR: tap_next = m ? sptap_pkg::ST_RESET : sptap_pkg::ST_CAP_IR;
			sptap_pkg::ST_CAP_IR: tap_next = m ? sptap_pkg::ST_EX1_IR : sptap_pkg::ST_SH_IR;
			sptap_pkg::ST_SH_IR: tap_next = m ? sptap_pkg::ST_EX1_IR : sptap_pkg::ST_SH_IR;
			sptap_pkg::ST_EX1_IR: tap_next = m ? sptap_pkg::ST_UP_IR : sptap_pkg::ST_PA_IR;
			sptap_pkg::ST_PA_IR: tap_next = m ? sptap_pkg::ST_EX2_IR : sptap_pkg::ST_PA_IR;
			sptap_pkg::ST_EX2_IR: tap_next = m ? sptap_pkg::ST_UP_IR : sptap_pkg::ST_SH_IR;
			sptap_pkg::ST_UP_IR: tap_next = m ? sptap_pkg::ST_SEL_DR : sptap_pkg::ST_IDLE;
			default: tap_next = sptap_pkg::ST_RESET;
		endcase
	endfunction : tap_next

	// length of the data path selected by an instruction; 1 means bypass
	function automatic logic [6:0] dr_len(logic [`SPTAP_IR_LEN-1:0] i);
		case (i)
			`SPTAP_I_ADDPLD: dr_len = 7'd`SPTAP_L_APLD;
			`SPTAP_I_DATPLD: dr_len = 7'd`SPTAP_L_DPLD;
			`SPTAP_I_ADDCFG: dr_len = 7'd`SPTAP_L_ACFG;
			`SPTAP_I_DATCFG: dr_len = 7'd`SPTAP_L_DCFG;
			`SPTAP_I_STATUS: dr_len = 7'd`SPTAP_L_STAT;
			`SPTAP_I_SHFUES: dr_len = 7'd`SPTAP_L_UES;
			`SPTAP_I_IDENT: dr_len = 7'd`SPTAP_ID_LEN;
			default: dr_len = 7'd1;
		endcase
	endfunction : dr_len

	// commands that act on entry to run-test/idle
	function automatic logic is_exec(logic [`SPTAP_IR_LEN-1:0] i);
		case (i)
			`SPTAP_I_ERSAND, `SPTAP_I_ERSARC, `SPTAP_I_PRGPLD, `SPTAP_I_PRGSEC,
			`SPTAP_I_ERSCFG, `SPTAP_I_PRGCFG, `SPTAP_I_ERSALL, `SPTAP_I_ERSUES,
			`SPTAP_I_PRGUES: is_exec = 1'b1;
			default: is_exec = 1'b0;
		endcase
	endfunction : is_exec

	// ************
	// test clock domain
	// ************
	sptap_pkg::sptap_tck_t t_ff;
	sptap_pkg::sptap_tck_t nxt_t;
	logic [6:0] len;
	logic trst;
	assign trst = t_ff.rst_s2;
	assign len = dr_len(t_ff.ir);

	always_comb begin
		nxt_t = t_ff;
		nxt_t.rst_s1 = rst;
		nxt_t.rst_s2 = t_ff.rst_s1;
		nxt_t.cmp_s1 = cmp_in;
		nxt_t.cmp_s2 = t_ff.cmp_s1;
		nxt_t.st = tap_next(t_ff.st, tms);
		case (t_ff.st)
			sptap_pkg::ST_RESET: begin
				nxt_t.ir = `SPTAP_I_IDENT;
			end
			sptap_pkg::ST_CAP_IR: begin
				nxt_t.ir_sh = `SPTAP_I_IDENT;
			end
			sptap_pkg::ST_SH_IR: begin
				nxt_t.ir_sh = {tdi, t_ff.ir_sh[`SPTAP_IR_LEN-1:1]};
			end
			sptap_pkg::ST_UP_IR: begin
				nxt_t.ir = t_ff.ir_sh;
			end
			sptap_pkg::ST_CAP_DR: begin
				nxt_t.dr_sh = '0;
				case (t_ff.ir)
					`SPTAP_I_ADDPLD: nxt_t.dr_sh[`SPTAP_L_APLD-1:0] = t_ff.nv.pld_addr;
					`SPTAP_I_DATPLD: nxt_t.dr_sh = t_ff.nv.pld_data;
					`SPTAP_I_ADDCFG: nxt_t.dr_sh[`SPTAP_L_ACFG-1:0] = t_ff.nv.cfg_addr;
					`SPTAP_I_DATCFG: nxt_t.dr_sh[`SPTAP_L_DCFG-1:0] = t_ff.nv.cfg_data;
					`SPTAP_I_SHFUES: nxt_t.dr_sh[`SPTAP_L_UES-1:0] = t_ff.nv.ues_data;
					`SPTAP_I_STATUS: nxt_t.dr_sh[`SPTAP_L_STAT-1:0] = t_ff.cmp_s2;
					`SPTAP_I_IDENT: nxt_t.dr_sh[`SPTAP_ID_LEN-1:0] = `SPTAP_ID_VALUE;
					default: nxt_t.dr_sh = '0;
				endcase
			end
			sptap_pkg::ST_SH_DR: begin
				// tdi enters at the top bit of the selected length
				for (int k = 0; k < `SPTAP_DR_MAX; k++) begin
					if (k == 32'(len) - 1)
						nxt_t.dr_sh[k] = tdi;
					else if (k < `SPTAP_DR_MAX - 1)
						nxt_t.dr_sh[k] = t_ff.dr_sh[k+1];
					else
						nxt_t.dr_sh[k] = 1'b0;
				end
			end
			sptap_pkg::ST_UP_DR: begin
				case (t_ff.ir)
					`SPTAP_I_ADDPLD: nxt_t.nv.pld_addr = t_ff.dr_sh[`SPTAP_L_APLD-1:0];
					`SPTAP_I_DATPLD: nxt_t.nv.pld_data = t_ff.dr_sh;
					`SPTAP_I_ADDCFG: nxt_t.nv.cfg_addr = t_ff.dr_sh[`SPTAP_L_ACFG-1:0];
					`SPTAP_I_DATCFG: nxt_t.nv.cfg_data = t_ff.dr_sh[`SPTAP_L_DCFG-1:0];
					`SPTAP_I_SHFUES: nxt_t.nv.ues_data = t_ff.dr_sh[`SPTAP_L_UES-1:0];
					default: nxt_t.nv = t_ff.nv;
				endcase
			end
			default: nxt_t.nv = t_ff.nv;
		endcase
		// program and erase commands fire on entry to run-test/idle
		// the instruction after update decides, so a freshly loaded code acts on this entry
		if (t_ff.st != sptap_pkg::ST_IDLE && nxt_t.st == sptap_pkg::ST_IDLE && is_exec(nxt_t.ir)) begin
			nxt_t.nv.cmd = nxt_t.ir;
			nxt_t.exec_tgl = ~t_ff.exec_tgl;
		end
		if (t_ff.rst_s2) begin
			nxt_t.st = sptap_pkg::ST_RESET;
			nxt_t.ir = `SPTAP_I_IDENT;
			nxt_t.ir_sh = '0;
			nxt_t.dr_sh = '0;
			nxt_t.exec_tgl = 1'b0;
			nxt_t.nv = '0;
		end
	end

	always_ff @(posedge tck) begin
		t_ff <= nxt_t;
	end

	// tdo changes only on falling tck, so the next device sees a half period of setup
	always_ff @(negedge tck) begin
		if (trst) begin
			tdo <= 1'b0;
			tdo_oe <= 1'b0;
		end else begin
			tdo <= (t_ff.st == sptap_pkg::ST_SH_IR) ? t_ff.ir_sh[0] : t_ff.dr_sh[0];
			tdo_oe <= (t_ff.st == sptap_pkg::ST_SH_IR) || (t_ff.st == sptap_pkg::ST_SH_DR);
		end
	end

	// ************
	// system clock domain
	// ************
	// the words stay still for many tck periods after the toggle, so they are caught as-is
	sptap_pkg::sptap_sys_t s_ff;
	sptap_pkg::sptap_sys_t nxt_s;

	always_comb begin
		nxt_s = s_ff;
		nxt_s.t_s1 = t_ff.exec_tgl;
		nxt_s.t_s2 = s_ff.t_s1;
		nxt_s.t_s3 = s_ff.t_s2;
		nxt_s.strobe = s_ff.t_s2 ^ s_ff.t_s3;
		if (s_ff.t_s2 ^ s_ff.t_s3)
			nxt_s.nv = t_ff.nv;
		if (rst)
			nxt_s = '0;
	end

	always_ff @(posedge ref_clk) begin
		if (ce || rst)
			s_ff <= nxt_s;
	end

	assign nv_out = s_ff.nv;
	assign nv_strobe = s_ff.strobe;

	// ************
	// checks
	// ************
	int unsigned tms_hi;
	always_ff @(posedge tck) begin
		if (trst || !tms)
			tms_hi <= 0;
		else if (tms_hi < 8)
			tms_hi <= tms_hi + 1;
	end

	sequence s_ir_update;
		t_ff.st == sptap_pkg::ST_UP_IR;
	endsequence

	chk_tms_reset: assert property (@(posedge tck) disable iff (trst)
		tms_hi >= 5 |-> t_ff.st == sptap_pkg::ST_RESET) else $error("tap not reset after five tms");
	chk_ir_capture: assert property (@(posedge tck) disable iff (trst)
		t_ff.st == sptap_pkg::ST_CAP_IR |=> t_ff.ir_sh == `SPTAP_I_IDENT)
		else $error("capture-ir did not load identification");
	chk_ir_update: assert property (@(posedge tck) disable iff (trst)
		s_ir_update |=> t_ff.ir == $past(t_ff.ir_sh)) else $error("instruction not updated");
	chk_bypass_zero: assert property (@(posedge tck) disable iff (trst)
		t_ff.st == sptap_pkg::ST_CAP_DR && t_ff.ir == `SPTAP_I_BYPASS |=> t_ff.dr_sh[0] == 1'b0)
		else $error("bypass capture not zero");
	chk_extest_bypass: assert property (@(posedge tck) disable iff (trst)
		t_ff.st == sptap_pkg::ST_SH_DR && (t_ff.ir == `SPTAP_I_EXTEST
		|| t_ff.ir == `SPTAP_I_SAMPLE) |=> t_ff.dr_sh[0] == $past(tdi))
		else $error("scan instruction not one-bit path");
	chk_id_capture: assert property (@(posedge tck) disable iff (trst)
		t_ff.st == sptap_pkg::ST_CAP_DR && t_ff.ir == `SPTAP_I_IDENT
		|=> t_ff.dr_sh[`SPTAP_ID_LEN-1:0] == `SPTAP_ID_VALUE) else $error("id word wrong");
	chk_status_snap: assert property (@(posedge tck) disable iff (trst)
		t_ff.st == sptap_pkg::ST_CAP_DR && t_ff.ir == `SPTAP_I_STATUS
		|=> t_ff.dr_sh[`SPTAP_L_STAT-1:0] == $past(t_ff.cmp_s2)) else $error("status not snapped");
	chk_exec_toggle: assert property (@(posedge tck) disable iff (trst)
		((t_ff.st == sptap_pkg::ST_UP_DR && is_exec(t_ff.ir))
		|| (t_ff.st == sptap_pkg::ST_UP_IR && is_exec(t_ff.ir_sh))) && !tms
		|=> t_ff.exec_tgl != $past(t_ff.exec_tgl) && t_ff.nv.cmd == t_ff.ir)
		else $error("program command not issued");
	chk_tdo_drive: assert property (@(posedge tck) disable iff (trst)
		t_ff.st == sptap_pkg::ST_SH_DR ##1 t_ff.st == sptap_pkg::ST_SH_DR |-> tdo_oe)
		else $error("tdo not driven in shift");
	chk_strobe_once: assert property (@(posedge ref_clk) disable iff (rst || !ce)
		nv_strobe |=> !nv_strobe) else $error("strobe longer than one cycle");
endmodule : sptap_core

// ### core/sptap_cfg.svh
/*
 * constants of the serial program tap: instruction codes, register lengths, identification word.
 * assumes inclusion by the package, the tap module and the bench; the guard allows repeats.
 */
`ifndef SPTAP_CFG_SVH
`define SPTAP_CFG_SVH
`define SPTAP_IR_LEN 6
`define SPTAP_DR_MAX 81
`define SPTAP_ID_LEN 32
// identification word: value is arbitrary
`define SPTAP_ID_VALUE 32'h0A5C_3E01
`define SPTAP_I_EXTEST 6'h00
`define SPTAP_I_ADDPLD 6'h01
`define SPTAP_I_DATPLD 6'h02
`define SPTAP_I_ERSAND 6'h03
`define SPTAP_I_ERSARC 6'h04
`define SPTAP_I_PRGPLD 6'h05
`define SPTAP_I_PRGSEC 6'h06
`define SPTAP_I_BYPASS 6'h3F
`define SPTAP_I_ADDCFG 6'h0A
`define SPTAP_I_DATCFG 6'h0B
`define SPTAP_I_ERSCFG 6'h0C
`define SPTAP_I_PRGCFG 6'h0D
`define SPTAP_I_ERSALL 6'h16
`define SPTAP_I_IDENT 6'h19
`define SPTAP_I_STATUS 6'h1B
`define SPTAP_I_SAMPLE 6'h1C
`define SPTAP_I_ERSUES 6'h1D
`define SPTAP_I_SHFUES 6'h1E
`define SPTAP_I_PRGUES 6'h1F
`define SPTAP_L_APLD 75
`define SPTAP_L_DPLD 81
`define SPTAP_L_ACFG 4
`define SPTAP_L_DCFG 41
`define SPTAP_L_STAT 12
`define SPTAP_L_UES 16
`endif

// ### core/sptap_pkg.sv
/*
 * types of the serial program tap.
 * assumes sptap_cfg.svh is on the include path.
 */
`include "sptap_cfg.svh"
package sptap_pkg;
	// one-hot tap controller states
	typedef enum logic [15:0] {
		ST_RESET = 16'h0001, ST_IDLE = 16'h0002, ST_SEL_DR = 16'h0004, ST_CAP_DR = 16'h0008,
		ST_SH_DR = 16'h0010, ST_EX1_DR = 16'h0020, ST_PA_DR = 16'h0040, ST_EX2_DR = 16'h0080,
		ST_UP_DR = 16'h0100, ST_SEL_IR = 16'h0200, ST_CAP_IR = 16'h0400, ST_SH_IR = 16'h0800,
		ST_EX1_IR = 16'h1000, ST_PA_IR = 16'h2000, ST_EX2_IR = 16'h4000, ST_UP_IR = 16'h8000
	} sptap_state_t;
	// configuration words committed towards nonvolatile memory
	typedef struct packed {
		logic [`SPTAP_IR_LEN-1:0] cmd;
		logic [`SPTAP_L_APLD-1:0] pld_addr;
		logic [`SPTAP_L_DPLD-1:0] pld_data;
		logic [`SPTAP_L_ACFG-1:0] cfg_addr;
		logic [`SPTAP_L_DCFG-1:0] cfg_data;
		logic [`SPTAP_L_UES-1:0] ues_data;
	} sptap_nv_t;
	// state on the test clock
	typedef struct packed {
		logic rst_s1;
		logic rst_s2;
		logic [`SPTAP_L_STAT-1:0] cmp_s1;
		logic [`SPTAP_L_STAT-1:0] cmp_s2;
		sptap_state_t st;
		logic [`SPTAP_IR_LEN-1:0] ir;
		logic [`SPTAP_IR_LEN-1:0] ir_sh;
		logic [`SPTAP_DR_MAX-1:0] dr_sh;
		logic exec_tgl;
		sptap_nv_t nv;
	} sptap_tck_t;
	// state on the system clock
	typedef struct packed {
		logic t_s1;
		logic t_s2;
		logic t_s3;
		logic strobe;
		sptap_nv_t nv;
	} sptap_sys_t;
endpackage : sptap_pkg

// ### tb/sptap_master.sv
/*
 * test-port master model: makes tck only inside frames and walks the controller.
 * assumes the device samples on rising tck and moves tdo on falling tck.
 */
`timescale 1ns/10ps
module sptap_master (
	// test port
	output logic tck,
	output logic tms,
	output logic tdi,
	input wire logic tdo
);
	// ****************
	// frame drivers
	// ****************
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
	end
	// one tck period; tms and tdi move only while tck is low
	task automatic step(input logic m, input logic d, output logic q);
		tms = m;
		tdi = d;
		#15 tck = 1'b1;
		q = tdo;
		#15 tck = 1'b0;
	endtask : step
	// five highs reach test-logic-reset from anywhere, then park in idle
	task automatic tlr();
		logic q;
		repeat (5) step(1'b1, 1'b0, q);
		step(1'b0, 1'b0, q);
	endtask : tlr
	// idle to idle scan, lsb first, tms high on the last bit
	task automatic scan(input logic ir, input int n, input logic [80:0] din,
			output logic [80:0] dout);
		logic q;
		dout = '0;
		step(1'b1, 1'b0, q);
		if (ir) step(1'b1, 1'b0, q);
		step(1'b0, 1'b0, q);
		step(1'b0, 1'b0, q);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, din[i], q);
			dout[i] = q;
		end
		step(1'b1, 1'b0, q);
		step(1'b0, 1'b0, q);
	endtask : scan
endmodule : sptap_master

// ### tb/serial_program_tap_bench.sv
/*
 * self-checking bench of the serial program tap.
 * assumes sptap_cfg.svh on the include path and the master model beside it.
 */
`timescale 1ns/10ps
`include "sptap_cfg.svh"
module serial_program_tap_bench;
	// ****************
	// wiring
	// ****************
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	logic [`SPTAP_L_STAT-1:0] cmp_in = 12'h000;
	logic tck, tms, tdi, tdo, tdo_oe, nv_strobe;
	sptap_pkg::sptap_nv_t nv_out;
	sptap_pkg::sptap_nv_t exp_nv = '0;
	logic [80:0] got;
	logic [80:0] pat = 81'h1_5A3C_96E1_0F2D_B487_C369;
	int error_cnt = 0;
	int checks_done = 0;
	int strobe_cnt = 0;
	always #2 ref_clk = ~ref_clk;
	always @(posedge ref_clk) if (nv_strobe === 1'b1) strobe_cnt <= strobe_cnt + 1;
	sptap_core sptap_core_i (.ref_clk(ref_clk), .rst(rst), .ce(ce), .tck(tck), .tms(tms),
		.tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .cmp_in(cmp_in), .nv_out(nv_out),
		.nv_strobe(nv_strobe));
	sptap_master sptap_master_i (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
	// ****************
	// checks and report
	// ****************
	task automatic cmp_bits(input string what, input logic [80:0] exp, input logic [80:0] seen);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : cmp_bits
	task automatic cmp_nv(input string what, input sptap_pkg::sptap_nv_t exp,
			input sptap_pkg::sptap_nv_t seen);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : cmp_nv
	task automatic conclude();
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : conclude
	// every instruction scan also proves what capture-ir loaded
	task automatic ir_load(input logic [5:0] code);
		sptap_master_i.scan(1'b1, `SPTAP_IR_LEN, {75'h0, code}, got);
		cmp_bits("ir capture", {75'h0, `SPTAP_I_IDENT}, got);
	endtask : ir_load
	// ****************
	// scenarios
	// ****************
	task automatic t_ident();
		sptap_master_i.scan(1'b0, `SPTAP_ID_LEN, 81'h0, got);
		cmp_bits("id after reset", {49'h0, `SPTAP_ID_VALUE}, got);
		cmp_bits("tdo_oe idle", 81'h0, {80'h0, tdo_oe});
		ir_load(`SPTAP_I_STATUS);
		sptap_master_i.tlr();
		sptap_master_i.scan(1'b0, `SPTAP_ID_LEN, 81'h0, got);
		cmp_bits("id after tlr", {49'h0, `SPTAP_ID_VALUE}, got);
		$display("test ident done");
	endtask : t_ident
	task automatic t_bypass();
		logic [5:0] codes [6] = '{`SPTAP_I_BYPASS, `SPTAP_I_EXTEST, `SPTAP_I_SAMPLE,
			6'h07, 6'h20, 6'h2A};
		foreach (codes[i]) begin
			ir_load(codes[i]);
			sptap_master_i.scan(1'b0, 8, 81'hB5, got);
			cmp_bits("bypass path", (81'hB5 << 1) & 81'hFF, got);
		end
		$display("test bypass done");
	endtask : t_bypass
	task automatic t_status(input logic [11:0] v);
		@(posedge ref_clk);
		cmp_in <= v;
		repeat (8) @(posedge ref_clk);
		ir_load(`SPTAP_I_STATUS);
		sptap_master_i.scan(1'b0, `SPTAP_L_STAT, 81'h0, got);
		cmp_bits("status", {69'h0, v}, got);
		$display("test status done");
	endtask : t_status
	task automatic t_regs();
		logic [5:0] codes [5] = '{`SPTAP_I_ADDPLD, `SPTAP_I_DATPLD, `SPTAP_I_ADDCFG,
			`SPTAP_I_DATCFG, `SPTAP_I_SHFUES};
		int lens [5] = '{`SPTAP_L_APLD, `SPTAP_L_DPLD, `SPTAP_L_ACFG, `SPTAP_L_DCFG, `SPTAP_L_UES};
		foreach (codes[i]) begin
			ir_load(codes[i]);
			sptap_master_i.scan(1'b0, lens[i], pat, got);
			sptap_master_i.scan(1'b0, lens[i], pat, got);
			cmp_bits("readback", pat & ((81'h1 << lens[i]) - 81'h1), got);
		end
		cmp_bits("no strobe on data", 81'h0, 81'(strobe_cnt));
		exp_nv.pld_addr = pat[74:0];
		exp_nv.pld_data = pat;
		exp_nv.cfg_addr = pat[3:0];
		exp_nv.cfg_data = pat[40:0];
		exp_nv.ues_data = pat[15:0];
		$display("test registers done");
	endtask : t_regs
	task automatic t_cmds();
		logic [5:0] cmds [9] = '{`SPTAP_I_ERSAND, `SPTAP_I_ERSARC, `SPTAP_I_PRGPLD,
			`SPTAP_I_PRGSEC, `SPTAP_I_ERSCFG, `SPTAP_I_PRGCFG, `SPTAP_I_ERSALL,
			`SPTAP_I_ERSUES, `SPTAP_I_PRGUES};
		int old;
		int n;
		foreach (cmds[i]) begin
			old = strobe_cnt;
			ir_load(cmds[i]);
			n = 0;
			while (strobe_cnt == old && n < 40) begin
				@(posedge ref_clk);
				n++;
			end
			if (n == 40) begin
				cmp_bits("strobe wait", 81'h1, 81'h0);
				conclude();
			end
			repeat (8) @(posedge ref_clk);
			cmp_bits("one strobe", 81'(old + 1), 81'(strobe_cnt));
			exp_nv.cmd = cmds[i];
			cmp_nv("nv_out", exp_nv, nv_out);
		end
		$display("test commands done");
	endtask : t_cmds
	initial begin
		repeat (12) @(posedge ref_clk);
		sptap_master_i.tlr();
		@(posedge ref_clk);
		rst <= 1'b0;
		sptap_master_i.tlr();
		t_ident();
		t_bypass();
		t_status(12'hA5C);
		t_status(12'h3A1);
		t_regs();
		t_cmds();
		conclude();
	end
endmodule : serial_program_tap_bench
